// [hw/jts_tap_select.sv]
// Test-port selector: routes the probe's JTAG pins to the fabric TAP or the
// core debug logic, gates fabric I/Os during programming and sequences
// nonvolatile page writes. All probe pins are sampled by clk_sys_i, so TCK
// must stay well below a quarter of the system clock.
//
// Behaviour
// - Select pin high routes fabric TAP, else core.
// - Fabric selected forces core debug reset low.
// - Context instruction switches target, pin ignored until test reset.
// - Fabric programming tristates or holds fabric I/Os.
// - Per-page write protection blocks program or erase.
// - Page program including erase takes 8 ms.
`timescale 1ns/100ps
`include "jts_defs.svh"

module jts_tap_select #(
    parameter int PAGE_PROG_CYCLES = `JTS_PAGE_PROG_CYC,
    parameter int NVM_PAGES        = `JTS_NVM_PAGES
) (
    // System
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    // Probe pins
    input  wire logic                        tck_i,
    input  wire logic                        tms_i,
    input  wire logic                        tdi_i,
    input  wire logic                        jtag_test_reset_n_i,
    input  wire logic                        tap_target_select_pin_i,
    output logic                             tdo_o,
    output logic                             tdo_oe_o,
    // Fabric TAP
    output logic                             fab_tck_o,
    output logic                             fab_tms_o,
    output logic                             fab_tdi_o,
    input  wire logic                        fab_tdo_i,
    // Core debug logic
    output logic                             core_tck_o,
    output logic                             core_tms_o,
    output logic                             core_tdi_o,
    input  wire logic                        core_tdo_i,
    output logic                             core_debug_test_reset_low_n_o,
    // Selection status
    output logic                             fpga_tap_selected_o,
    output logic                             ctx_override_o,
    // Fabric programming
    input  wire logic                        fabric_prog_active_i,
    input  wire jts_pkg::jts_io_mode_e       io_mode_i,
    output logic                             fab_io_tristate_o,
    output logic                             fab_io_hold_o,
    output logic                             mcu_io_enable_o,
    // Nonvolatile page requests
    input  wire logic                        nvm_req_valid_i,
    input  wire logic [$clog2(NVM_PAGES)-1:0] nvm_req_page_i,
    input  wire logic                        nvm_req_protect_i,
    output logic                             nvm_req_ready_o,
    output logic                             nvm_start_o,
    output logic                             nvm_busy_o,
    output logic                             nvm_done_o,
    output logic                             nvm_refused_o
);

    localparam int CNT_W = $clog2(PAGE_PROG_CYCLES + 1);
    localparam int IR_W  = `JTS_IR_WIDTH;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser on every pin; stage one feeds only stage two.
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic       tck_d_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= `JTS_SYNC_RST;
            sync2_ff <= `JTS_SYNC_RST;
            tck_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {core_tdo_i, fab_tdo_i, tap_target_select_pin_i,
                         jtag_test_reset_n_i, tdi_i, tms_i, tck_i};
            sync2_ff <= sync1_ff;
            tck_d_ff <= sync2_ff[0];
        end
    end

    wire tck_s      = sync2_ff[0];
    wire tms_s      = sync2_ff[1];
    wire tdi_s      = sync2_ff[2];
    wire trst_n_s   = sync2_ff[3];
    wire sel_pin_s  = sync2_ff[4];
    wire fab_tdo_s  = sync2_ff[5];
    wire core_tdo_s = sync2_ff[6];
    wire tck_rise   = tck_s & ~tck_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // Shadow TAP and instruction register, used to find the context
    // instruction and the quiet states in which the pin may be sampled.
    jts_pkg::jts_tap_e tap_ff;
    jts_pkg::jts_tap_e nxt_tap;
    logic [IR_W-1:0]   ir_ff;
    logic              sel_pin_ff;
    logic              ctx_valid_ff;
    logic              ctx_target_ff;

    assign nxt_tap = !trst_n_s ? jts_pkg::TAP_RESET
                   : tck_rise  ? jts_pkg::tap_next(tap_ff, tms_s) : tap_ff;

    wire tap_quiet = (tap_ff == jts_pkg::TAP_RESET) ||
                     (tap_ff == jts_pkg::TAP_IDLE);
    wire ctx_cmd   = tck_rise && trst_n_s &&
                     (nxt_tap == jts_pkg::TAP_UPD_IR) &&
                     (tap_ff != jts_pkg::TAP_UPD_IR) &&
                     (ir_ff == `JTS_CTX_OPCODE);
    wire sel_eff   = ctx_valid_ff ? ctx_target_ff : sel_pin_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tap_ff <= jts_pkg::TAP_RESET;
            ir_ff  <= `JTS_IR_RST;
        end else begin
            tap_ff <= nxt_tap;
            if (tck_rise && tap_ff == jts_pkg::TAP_SH_IR)
                ir_ff <= {tdi_s, ir_ff[IR_W-1:1]};
        end
    end

    // A pin change mid-shift would tear a scan apart, so it waits.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            sel_pin_ff <= `JTS_SEL_RST;
        else if (tap_quiet)
            sel_pin_ff <= sel_pin_s;
    end

    // The override lasts until a test reset, then the pin rules again.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctx_valid_ff  <= 1'b0;
            ctx_target_ff <= `JTS_SEL_RST;
        end else if (!trst_n_s) begin
            ctx_valid_ff  <= 1'b0;
        end else if (ctx_cmd) begin
            ctx_valid_ff  <= 1'b1;
            ctx_target_ff <= ~sel_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing. The target not selected sees TCK low and TMS high.
    wire shifting = (tap_ff == jts_pkg::TAP_SH_DR) ||
                    (tap_ff == jts_pkg::TAP_SH_IR);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fab_tck_o  <= 1'b0;
            fab_tms_o  <= 1'b1;
            fab_tdi_o  <= 1'b0;
            core_tck_o <= 1'b0;
            core_tms_o <= 1'b1;
            core_tdi_o <= 1'b0;
            tdo_o      <= 1'b0;
            tdo_oe_o   <= 1'b0;
            core_debug_test_reset_low_n_o <= 1'b0;
        end else begin
            fab_tck_o  <= sel_eff & tck_s;
            fab_tms_o  <= sel_eff ? tms_s : 1'b1;
            fab_tdi_o  <= sel_eff & tdi_s;
            core_tck_o <= ~sel_eff & tck_s;
            core_tms_o <= sel_eff ? 1'b1 : tms_s;
            core_tdi_o <= ~sel_eff & tdi_s;
            tdo_o      <= sel_eff ? fab_tdo_s : core_tdo_s;
            tdo_oe_o   <= shifting;
            core_debug_test_reset_low_n_o <= ~sel_eff & trst_n_s;
        end
    end

    assign fpga_tap_selected_o = sel_eff;
    assign ctx_override_o      = ctx_valid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Fabric I/O gating while the fabric is programmed.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fab_io_tristate_o <= 1'b0;
            fab_io_hold_o     <= 1'b0;
        end else begin
            fab_io_tristate_o <= fabric_prog_active_i &&
                                 io_mode_i == jts_pkg::IO_TRISTATE;
            fab_io_hold_o     <= fabric_prog_active_i &&
                                 io_mode_i != jts_pkg::IO_TRISTATE;
        end
    end

    // Subsystem I/Os never stop, they carry the new image.
    assign mcu_io_enable_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Page programming: one page of JTS_PAGE_BYTES at a time.
    logic [NVM_PAGES-1:0] prot_ff;
    logic [CNT_W-1:0]     cnt_ff;
    logic                 start_ff;
    logic                 done_ff;
    logic                 refused_ff;

    wire accept   = nvm_req_valid_i && nvm_req_ready_o;
    wire page_prt = prot_ff[nvm_req_page_i];
    wire do_prog  = accept && !nvm_req_protect_i && !page_prt;

    assign nvm_req_ready_o = (cnt_ff == '0);
    assign nvm_busy_o      = (cnt_ff != '0);
    assign nvm_start_o     = start_ff;
    assign nvm_done_o      = done_ff;
    assign nvm_refused_o   = refused_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prot_ff    <= '0;
            cnt_ff     <= '0;
            start_ff   <= 1'b0;
            done_ff    <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            if (accept && nvm_req_protect_i)
                prot_ff[nvm_req_page_i] <= 1'b1;
            if (do_prog)
                cnt_ff <= CNT_W'(PAGE_PROG_CYCLES);
            else if (cnt_ff != '0)
                cnt_ff <= cnt_ff - CNT_W'(1);
            start_ff   <= do_prog;
            done_ff    <= (cnt_ff == CNT_W'(1));
            refused_ff <= accept && !nvm_req_protect_i && page_prt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_route_fab;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_eff |=> (fab_tms_o == $past(tms_s)) && core_tms_o && !core_tck_o;
    endproperty
    a_route_fab: assert property (p_route_fab)
        else $error("Fabric TAP not routed while selected.");
    property p_route_core;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !sel_eff |=> (tdo_o == $past(core_tdo_s)) && fab_tms_o;
    endproperty
    a_route_core: assert property (p_route_core)
        else $error("Core debug not routed while selected.");
    property p_core_reset;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_eff ##1 sel_eff |-> !core_debug_test_reset_low_n_o;
    endproperty
    a_core_reset: assert property (p_core_reset)
        else $error("Core debug reset released while fabric selected.");
    property p_ctx_switch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ctx_cmd |=> ctx_valid_ff && (sel_eff != $past(sel_eff));
    endproperty
    a_ctx_switch: assert property (p_ctx_switch)
        else $error("Context instruction did not switch the target.");
    property p_io_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        fabric_prog_active_i |=> fab_io_tristate_o ^ fab_io_hold_o;
    endproperty
    a_io_gate: assert property (p_io_gate)
        else $error("Fabric I/Os neither tristated nor held.");
    property p_protect;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        accept && !nvm_req_protect_i && page_prt |=> refused_ff && !start_ff;
    endproperty
    a_protect: assert property (p_protect)
        else $error("Protected page was programmed.");
    property p_prog_time;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(nvm_busy_o) |-> cnt_ff == CNT_W'(PAGE_PROG_CYCLES);
    endproperty
    a_prog_time: assert property (p_prog_time)
        else $error("Page program time not loaded.");
    property p_pin_quiet;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !tap_quiet |=> $stable(sel_pin_ff);
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("Select pin sampled outside reset or idle.");

    c_ctx:   cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                             ctx_cmd);
    c_done:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                             nvm_done_o);
    c_swap:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
                             $fell(sel_pin_ff));

endmodule // jts_tap_select

// [hw/jts_defs.svh]
// Constants of the test-port selector: timing, sizes, opcode, reset values.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef JTS_DEFS_SVH
`define JTS_DEFS_SVH

`define JTS_CLK_MHZ           20
`define JTS_PAGE_PROG_TIME_US 8000
`define JTS_PAGE_PROG_CYC     (`JTS_PAGE_PROG_TIME_US * `JTS_CLK_MHZ)
`define JTS_PAGE_BYTES        132
`define JTS_NVM_PAGES         16
`define JTS_IR_WIDTH          8
`define JTS_CTX_OPCODE        8'h7A
`define JTS_IR_RST            8'hFF
// Synchroniser reset: {core_tdo, fab_tdo, sel, trst_n, tdi, tms, tck}.
`define JTS_SYNC_RST          7'h52
`define JTS_SEL_RST           1'b1

`endif

// [hw/jts_pkg.sv]
// Types and the TAP next-state function shared by the test-port selector.
// Assumes jts_defs.svh for numeric constants.
package jts_pkg;

    typedef enum logic [15:0] {
        TAP_RESET   = 16'h0001, TAP_IDLE    = 16'h0002,
        TAP_SEL_DR  = 16'h0004, TAP_CAP_DR  = 16'h0008,
        TAP_SH_DR   = 16'h0010, TAP_EX1_DR  = 16'h0020,
        TAP_PA_DR   = 16'h0040, TAP_EX2_DR  = 16'h0080,
        TAP_UPD_DR  = 16'h0100, TAP_SEL_IR  = 16'h0200,
        TAP_CAP_IR  = 16'h0400, TAP_SH_IR   = 16'h0800,
        TAP_EX1_IR  = 16'h1000, TAP_PA_IR   = 16'h2000,
        TAP_EX2_IR  = 16'h4000, TAP_UPD_IR  = 16'h8000
    } jts_tap_e;

    // Fabric I/O behaviour while the fabric is being programmed.
    typedef enum logic [2:0] {
        IO_TRISTATE = 3'h1,
        IO_HOLD_DEF = 3'h2,
        IO_HOLD_LAST = 3'h4
    } jts_io_mode_e;

    // Next state of the standard test-access-port controller on a TCK rise.
    function automatic jts_tap_e tap_next(input jts_tap_e s, input logic m);
        unique case (s)
            TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default:    tap_next = TAP_RESET;
        endcase
    endfunction

endpackage

// [verif/jts_probe_model.sv]
// Probe model: drives the JTAG pins one TCK period at a time.
// Assumes clk_sys_i from the bench; pins change 1 ns after its rising edge.
`timescale 1ns/100ps
module jts_probe_model (
    // System
    input  wire logic clk_sys_i,
    // Probe pins
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      trst_n_o,
    output logic      sel_o
);
////////////////////////////////////////////////////////////////////////////
    initial begin
        tck_o    = 1'b0;
        tms_o    = 1'b1;
        tdi_o    = 1'b0;
        trst_n_o = 1'b1;
        sel_o    = 1'b1;
    end
    // TCK stands low between bits; 4 system clocks per phase gives 200 ns, a 400 ns TCK period.
    task automatic pulse(input logic m, input logic d);
        @(posedge clk_sys_i);
        #1;
        tms_o = m;
        tdi_o = d;
        repeat (3) @(posedge clk_sys_i);
        #1;
        tck_o = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        tck_o = 1'b0;
        tdi_o = ~d;
    endtask
    task automatic set_pins(input logic sel, input logic trst_n);
        @(posedge clk_sys_i);
        #1;
        sel_o    = sel;
        trst_n_o = trst_n;
    endtask
    task automatic tap_reset;
        repeat (5) pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b0);
    endtask
    // From Run-Test/Idle, shift an instruction LSB first and update it.
    task automatic load_ir(input logic [7:0] v);
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            pulse(i == 7, v[i]);
        end
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b0);
    endtask
endmodule // jts_probe_model

// [verif/jts_tap_select_tb.sv]
// Testbench of the test-port selector with a probe model on the JTAG pins.
// Assumes a 20 MHz clock and a shortened page program time.
`timescale 1ns/100ps
module jts_tap_select_tb;
    localparam int P  = 20;
    localparam int NP = 16;
    logic                  clk_sys_i = 1'b0;
    logic                  rst_n_i   = 1'b0;
    logic                  tck, tms, tdi, trst_n, sel;
    logic                  fab_tms, core_tms, core_rst_n, fpga_sel, ovr;
    logic                  tdo, tdo_oe, fab_tck, fab_tdi, core_tck, core_tdi;
    logic                  fab_tdo  = 1'b1;
    logic                  core_tdo = 1'b0;
    logic                  prog = 1'b0;
    jts_pkg::jts_io_mode_e mode = jts_pkg::IO_TRISTATE;
    logic                  io_tri, io_hold, mcu_en;
    logic                  valid = 1'b0;
    logic [$clog2(NP)-1:0] page  = '0;
    logic                  prot  = 1'b0;
    logic                  ready, start, busy, done, refused;
    int                    errors = 0;
    int                    num_checks = 0;
////////////////////////////////////////////////////////////////////////////
    always #25 clk_sys_i = ~clk_sys_i;
    jts_probe_model jts_probe_model_i (.clk_sys_i(clk_sys_i), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .sel_o(sel));
    jts_tap_select #(.PAGE_PROG_CYCLES(P), .NVM_PAGES(NP)) jts_tap_select_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .jtag_test_reset_n_i(trst_n),
        .tap_target_select_pin_i(sel), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .fab_tck_o(fab_tck), .fab_tms_o(fab_tms), .fab_tdi_o(fab_tdi),
        .fab_tdo_i(fab_tdo),
        .core_tck_o(core_tck), .core_tms_o(core_tms), .core_tdi_o(core_tdi),
        .core_tdo_i(core_tdo), .core_debug_test_reset_low_n_o(core_rst_n),
        .fpga_tap_selected_o(fpga_sel), .ctx_override_o(ovr),
        .fabric_prog_active_i(prog), .io_mode_i(mode),
        .fab_io_tristate_o(io_tri), .fab_io_hold_o(io_hold),
        .mcu_io_enable_o(mcu_en), .nvm_req_valid_i(valid),
        .nvm_req_page_i(page), .nvm_req_protect_i(prot),
        .nvm_req_ready_o(ready), .nvm_start_o(start), .nvm_busy_o(busy),
        .nvm_done_o(done), .nvm_refused_o(refused));
////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // A TCK pulse in Run-Test/Idle must reach only the selected target.
    task automatic tck_seen(input logic fab);
        fork
            jts_probe_model_i.pulse(1'b0, 1'b0);
            begin
                settle(8);
                check("fab_tck", fab_tck, fab);
                check("core_tck", core_tck, !fab);
            end
        join
    endtask
    task automatic t_route;
        jts_probe_model_i.tap_reset();
        settle(8);
        check("fpga_sel", fpga_sel, 1'b1);
        check("fab_tms", fab_tms, 1'b0);
        check("core_tms", core_tms, 1'b1);
        check("core_rst_n", core_rst_n, 1'b0);
        check("tdo", tdo, 1'b1);
        check("fab_tdi", fab_tdi, 1'b1);
        check("core_tdi", core_tdi, 1'b0);
        tck_seen(1'b1);
        fab_tdo  = 1'b0;
        core_tdo = 1'b1;
        jts_probe_model_i.set_pins(1'b0, 1'b1);
        settle(8);
        check("fpga_sel", fpga_sel, 1'b0);
        check("core_tms", core_tms, 1'b0);
        check("fab_tms", fab_tms, 1'b1);
        check("core_rst_n", core_rst_n, 1'b1);
        check("tdo", tdo, 1'b1);
        check("fab_tdi", fab_tdi, 1'b0);
        check("core_tdi", core_tdi, 1'b1);
        tck_seen(1'b0);
        $display("test route done");
    endtask
    // A pin change in mid-shift must wait for the TAP to reach reset or Run-Test/Idle.
    task automatic t_defer;
        jts_probe_model_i.pulse(1'b1, 1'b0);
        jts_probe_model_i.pulse(1'b0, 1'b0);
        jts_probe_model_i.pulse(1'b0, 1'b0);
        jts_probe_model_i.set_pins(1'b1, 1'b1);
        settle(8);
        check("fpga_sel", fpga_sel, 1'b0);
        check("tdo_oe", tdo_oe, 1'b1);
        jts_probe_model_i.tap_reset();
        settle(8);
        check("fpga_sel", fpga_sel, 1'b1);
        check("tdo_oe", tdo_oe, 1'b0);
        $display("test defer done");
    endtask
    task automatic t_ctx;
        jts_probe_model_i.load_ir(8'h7B);
        settle(4);
        check("ovr", ovr, 1'b0);
        jts_probe_model_i.load_ir(8'h7A);
        settle(4);
        check("ovr", ovr, 1'b1);
        check("fpga_sel", fpga_sel, 1'b0);
        check("core_rst_n", core_rst_n, 1'b1);
        jts_probe_model_i.load_ir(8'h7A);
        jts_probe_model_i.set_pins(1'b0, 1'b1);
        settle(8);
        check("fpga_sel", fpga_sel, 1'b1);
        check("core_rst_n", core_rst_n, 1'b0);
        jts_probe_model_i.set_pins(1'b0, 1'b0);
        settle(8);
        check("ovr", ovr, 1'b0);
        check("fpga_sel", fpga_sel, 1'b0);
        jts_probe_model_i.set_pins(1'b1, 1'b1);
        jts_probe_model_i.tap_reset();
        $display("test context done");
    endtask
    task automatic t_io;
        jts_pkg::jts_io_mode_e m [3];
        m = '{jts_pkg::IO_TRISTATE, jts_pkg::IO_HOLD_DEF,
              jts_pkg::IO_HOLD_LAST};
        for (int i = 0; i < 3; i++) begin
            settle(1);
            prog = 1'b1;
            mode = m[i];
            settle(2);
            check("io_tri", io_tri, m[i] == jts_pkg::IO_TRISTATE);
            check("io_hold", io_hold, m[i] != jts_pkg::IO_TRISTATE);
            check("mcu_en", mcu_en, 1'b1);
        end
        prog = 1'b0;
        settle(2);
        check("io_tri", io_tri, 1'b0);
        check("io_hold", io_hold, 1'b0);
        $display("test io done");
    endtask
    task automatic req(input logic [$clog2(NP)-1:0] pg, input logic pr);
        settle(1);
        valid = 1'b1;
        page  = pg;
        prot  = pr;
        settle(1);
        valid = 1'b0;
    endtask
    task automatic prog_page(input logic [$clog2(NP)-1:0] pg);
        req(pg, 1'b0);
        check("start", start, 1'b1);
        check("ready", ready, 1'b0);
        settle(P - 1);
        check("busy", busy, 1'b1);
        check("done", done, 1'b0);
        settle(1);
        check("done", done, 1'b1);
        check("busy", busy, 1'b0);
    endtask
    task automatic t_nvm;
        prog_page(4'(NP - 1));
        req(4'(NP - 1), 1'b1);
        check("start", start, 1'b0);
        req(4'(NP - 1), 1'b0);
        check("refused", refused, 1'b1);
        check("busy", busy, 1'b0);
        prog_page(4'(NP - 2));
        $display("test nvm done");
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys_i);
        #1;
        check("core_rst_n", core_rst_n, 1'b0);
        check("ready", ready, 1'b1);
        rst_n_i = 1'b1;
        settle(4);
        t_route();
        t_defer();
        t_ctx();
        t_io();
        t_nvm();
        close_out();
    end
    // The tests need about 33 us; some twelve times that means a hang.
    initial begin
        #400000;
        errors++;
        close_out();
    end
endmodule // jts_tap_select_tb
